// ---- verilog/rcwt_pkg.sv ----
`default_nettype none
package rcwt_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [9:0] OFS_CHAN_MID   = 10'h301;
  localparam logic [9:0] OFS_CHAN_HIGH  = 10'h302;
  localparam logic [9:0] OFS_TX_MOD     = 10'h306;
  localparam logic [9:0] OFS_PWR_RB     = 10'h30C;
  localparam logic [9:0] OFS_SQI_RB     = 10'h30D;
  localparam logic [9:0] OFS_PRAM_PAGE  = 10'h313;
  localparam logic [9:0] OFS_TX_BASE    = 10'h314;
  localparam logic [9:0] OFS_RX_BASE    = 10'h315;
  localparam logic [9:0] OFS_DIV_STAGE  = 10'h316;
  localparam logic [9:0] OFS_SLEEP_CFG  = 10'h317;
  localparam logic [9:0] OFS_RLD_HIGH   = 10'h318;
  localparam logic [9:0] OFS_RLD_LOW    = 10'h319;
  localparam logic [9:0] OFS_TMR_CTRL   = 10'h31A;

  // ----------------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_CHAN_MID   = 8'hA9;
  localparam logic [7:0] RST_CHAN_HIGH  = 8'h03;
  localparam logic [7:0] RST_TX_MOD     = 8'h01;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_TX_BASE    = 8'h80;
  localparam int         BIT_PREEMP     = 0;
  localparam int         BIT_WAKE_EN    = 0;
  localparam int         SLEEP_LSB      = 3;
  localparam int         DIV_LSB        = 0;
  localparam int         PAGE_LSB       = 0;
  localparam int         BIT_FLAG_CLR   = 0;
  localparam int         BIT_CAL_EN     = 1;

  // ----------------------------------------------------------------------
  // Sleep retention codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] SLEEP_KEEP_BACKUP_RAM      = 4'h1;
  localparam logic [3:0] SLEEP_KEEP_CRYSTAL         = 4'h4;
  localparam logic [3:0] SLEEP_KEEP_RAM_AND_CRYSTAL = 4'h5;
  localparam logic [3:0] SLEEP_KEEP_RAM_AND_RC      = 4'hB;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int CAL_TIME_NS   = 1000000;
  localparam int CAL_CYCLES    = CAL_TIME_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } rcwt_req_t;

  typedef struct packed {
    logic       upd;
    logic [7:0] rssi;
    logic [7:0] sqi;
  } rcwt_radio_t;

endpackage : rcwt_pkg
`default_nettype wire

// ---- verilog/rcwt_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module rcwt_regs #(
  parameter int unsigned CAL_CYCLES = rcwt_pkg::CAL_CYCLES
) (
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_n_in,
  input  wire rcwt_pkg::rcwt_req_t   req_in,
  input  wire rcwt_pkg::rcwt_radio_t radio_in,
  input  wire logic                  ctrl_upd_in,
  input  wire logic [6:0]            ctrl_bits_in,
  input  wire logic                  slow_osc_in,
  output logic [7:0]                 rdata_out,
  output logic                       rvalid_out,
  output logic [15:0]                channel_word_hi_out,
  output logic                       preemp_en_out,
  output logic [3:0]                 pram_page_out,
  output logic [7:0]                 tx_base_out,
  output logic [7:0]                 rx_base_out,
  output logic                       keep_ram_out,
  output logic                       keep_crystal_out,
  output logic                       keep_rc_out,
  output logic                       wake_req_out,
  output logic                       expiry_flag_out,
  output logic                       cold_start_flag_out,
  output logic                       rc_osc_calibrate_enable_out,
  output logic                       rc_calibration_done_out
);

  // ----------------------------------------------------------------------
  // Host write decode
  // ----------------------------------------------------------------------
  logic        wr_mid, wr_high, wr_txm, wr_page, wr_txb, wr_rxb;
  logic        wr_div, wr_sleep, wr_rh, wr_rl, wr_ctrl;
  logic [7:0]  wd;
  assign wd       = req_in.wdata;
  assign wr_mid   = req_in.wr && req_in.addr == rcwt_pkg::OFS_CHAN_MID;
  assign wr_high  = req_in.wr && req_in.addr == rcwt_pkg::OFS_CHAN_HIGH;
  assign wr_txm   = req_in.wr && req_in.addr == rcwt_pkg::OFS_TX_MOD;
  assign wr_page  = req_in.wr && req_in.addr == rcwt_pkg::OFS_PRAM_PAGE;
  assign wr_txb   = req_in.wr && req_in.addr == rcwt_pkg::OFS_TX_BASE;
  assign wr_rxb   = req_in.wr && req_in.addr == rcwt_pkg::OFS_RX_BASE;
  assign wr_div   = req_in.wr && req_in.addr == rcwt_pkg::OFS_DIV_STAGE;
  assign wr_sleep = req_in.wr && req_in.addr == rcwt_pkg::OFS_SLEEP_CFG;
  assign wr_rh    = req_in.wr && req_in.addr == rcwt_pkg::OFS_RLD_HIGH;
  assign wr_rl    = req_in.wr && req_in.addr == rcwt_pkg::OFS_RLD_LOW;
  assign wr_ctrl  = req_in.wr && req_in.addr == rcwt_pkg::OFS_TMR_CTRL;

  // ----------------------------------------------------------------------
  // Radio configuration registers
  // ----------------------------------------------------------------------
  logic [6:0] ctrl_bits_reg;
  logic [7:0] rssi_reg, sqi_reg;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      channel_word_hi_out <= {rcwt_pkg::RST_CHAN_HIGH, rcwt_pkg::RST_CHAN_MID};
      preemp_en_out       <= rcwt_pkg::RST_TX_MOD[rcwt_pkg::BIT_PREEMP];
      pram_page_out       <= rcwt_pkg::RST_ZERO[3:0];
      tx_base_out         <= rcwt_pkg::RST_TX_BASE;
      rx_base_out         <= rcwt_pkg::RST_ZERO;
    end
    else
    begin
      if (wr_mid)
        channel_word_hi_out[7:0] <= wd;
      if (wr_high)
        channel_word_hi_out[15:8] <= wd;
      if (wr_txm)
        preemp_en_out <= wd[rcwt_pkg::BIT_PREEMP];
      if (wr_page)
        pram_page_out <= wd[rcwt_pkg::PAGE_LSB +: 4];
      if (wr_txb)
        tx_base_out <= wd;
      if (wr_rxb)
        rx_base_out <= wd;
    end
  end

  // Host writes to the upper modulation bits are dropped on purpose.
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      ctrl_bits_reg <= rcwt_pkg::RST_TX_MOD[7:1];
    else if (ctrl_upd_in)
      ctrl_bits_reg <= ctrl_bits_in;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      rssi_reg <= rcwt_pkg::RST_ZERO;
      sqi_reg  <= rcwt_pkg::RST_ZERO;
    end
    else if (radio_in.upd)
    begin
      rssi_reg <= radio_in.rssi;
      sqi_reg  <= radio_in.sqi;
    end
  end

  // ----------------------------------------------------------------------
  // Staged wake-up timer configuration
  // ----------------------------------------------------------------------
  logic [2:0]  div_stage_reg, div_code_reg;
  logic [3:0]  sleep_code_reg;
  logic        wake_en_reg;
  logic [7:0]  rld_stage_reg;
  logic [15:0] reload_reg;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      div_stage_reg  <= rcwt_pkg::RST_ZERO[2:0];
      div_code_reg   <= rcwt_pkg::RST_ZERO[2:0];
      sleep_code_reg <= rcwt_pkg::RST_ZERO[3:0];
      wake_en_reg    <= 1'b0;
    end
    else
    begin
      if (wr_div)
        div_stage_reg <= wd[rcwt_pkg::DIV_LSB +: 3];
      if (wr_sleep)
      begin
        div_code_reg   <= div_stage_reg;
        sleep_code_reg <= wd[rcwt_pkg::SLEEP_LSB +: 4];
        wake_en_reg    <= wd[rcwt_pkg::BIT_WAKE_EN];
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      keep_ram_out     <= 1'b0;
      keep_crystal_out <= 1'b0;
      keep_rc_out      <= 1'b0;
    end
    else
    begin
      keep_ram_out     <= sleep_code_reg == rcwt_pkg::SLEEP_KEEP_BACKUP_RAM ||
                          sleep_code_reg == rcwt_pkg::SLEEP_KEEP_RAM_AND_CRYSTAL ||
                          sleep_code_reg == rcwt_pkg::SLEEP_KEEP_RAM_AND_RC;
      keep_crystal_out <= sleep_code_reg == rcwt_pkg::SLEEP_KEEP_CRYSTAL ||
                          sleep_code_reg == rcwt_pkg::SLEEP_KEEP_RAM_AND_CRYSTAL;
      keep_rc_out      <= sleep_code_reg == rcwt_pkg::SLEEP_KEEP_RAM_AND_RC;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      rld_stage_reg <= rcwt_pkg::RST_ZERO;
      reload_reg    <= {rcwt_pkg::RST_ZERO, rcwt_pkg::RST_ZERO};
    end
    else
    begin
      if (wr_rh)
        rld_stage_reg <= wd;
      if (wr_rl)
        reload_reg <= {rld_stage_reg, wd};
    end
  end

  // ----------------------------------------------------------------------
  // Slow clock prescaler and timer
  // ----------------------------------------------------------------------
  // The oscillator pin is asynchronous; a third flop gives the edge.
  logic        slow_s1_reg, slow_s2_reg, slow_s3_reg;
  logic        slow_edge, tick;
  logic [15:0] pre_cnt_reg, pre_limit, timer_cnt_reg;
  logic        expire;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      slow_s1_reg <= 1'b0;
      slow_s2_reg <= 1'b0;
      slow_s3_reg <= 1'b0;
    end
    else
    begin
      slow_s1_reg <= slow_osc_in;
      slow_s2_reg <= slow_s1_reg;
      slow_s3_reg <= slow_s2_reg;
    end
  end
  assign slow_edge = slow_s2_reg && !slow_s3_reg;

  always_comb
  begin
    case (div_code_reg)
      3'h0:    pre_limit = 16'h0000;
      3'h1:    pre_limit = 16'h0003;
      3'h2:    pre_limit = 16'h0007;
      3'h3:    pre_limit = 16'h000F;
      3'h4:    pre_limit = 16'h007F;
      3'h5:    pre_limit = 16'h03FF;
      3'h6:    pre_limit = 16'h1FFF;
      default: pre_limit = 16'hFFFF;
    endcase
  end
  assign tick   = slow_edge && pre_cnt_reg == pre_limit;
  assign expire = tick && timer_cnt_reg <= 16'h0001;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in || wr_sleep)
      pre_cnt_reg <= 16'h0000;
    else if (tick)
      pre_cnt_reg <= 16'h0000;
    else if (slow_edge)
      pre_cnt_reg <= pre_cnt_reg + 16'h0001;
  end

  // A reload of N expires on the Nth tick; zero expires on every tick.
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      timer_cnt_reg <= 16'h0000;
    else if (wr_rl)
      timer_cnt_reg <= {rld_stage_reg, wd};
    else if (expire)
      timer_cnt_reg <= reload_reg;
    else if (tick)
      timer_cnt_reg <= timer_cnt_reg - 16'h0001;
  end

  // ----------------------------------------------------------------------
  // Status flags and timer control
  // ----------------------------------------------------------------------
  logic flag_clr;
  logic flag_clr_bit_reg;
  assign flag_clr = wr_ctrl && wd[rcwt_pkg::BIT_FLAG_CLR];

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      flag_clr_bit_reg            <= 1'b0;
      rc_osc_calibrate_enable_out <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      flag_clr_bit_reg            <= wd[rcwt_pkg::BIT_FLAG_CLR];
      rc_osc_calibrate_enable_out <= wd[rcwt_pkg::BIT_CAL_EN];
    end
  end

  // Reset is the cold start, so the flag comes up set; a new expiry beats a clear.
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      expiry_flag_out     <= 1'b0;
      cold_start_flag_out <= 1'b1;
      wake_req_out        <= 1'b0;
    end
    else
    begin
      if (expire)
        expiry_flag_out <= 1'b1;
      else if (flag_clr)
        expiry_flag_out <= 1'b0;
      if (flag_clr)
        cold_start_flag_out <= 1'b0;
      wake_req_out <= expire && wake_en_reg;
    end
  end

  // ----------------------------------------------------------------------
  // RC oscillator calibration
  // ----------------------------------------------------------------------
  logic [15:0] cal_cnt_reg;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in || !rc_osc_calibrate_enable_out)
    begin
      cal_cnt_reg             <= 16'h0000;
      rc_calibration_done_out <= 1'b0;
    end
    else if (cal_cnt_reg == 16'(CAL_CYCLES - 1))
      rc_calibration_done_out <= 1'b1;
    else
      cal_cnt_reg <= cal_cnt_reg + 16'h0001;
  end

  // ----------------------------------------------------------------------
  // Host read path
  // ----------------------------------------------------------------------
  logic [7:0] rd_mux;

  // Staged registers are write-only and read back as zero.
  always_comb
  begin
    rd_mux = 8'h00;
    case (req_in.addr)
      rcwt_pkg::OFS_CHAN_MID:  rd_mux = channel_word_hi_out[7:0];
      rcwt_pkg::OFS_CHAN_HIGH: rd_mux = channel_word_hi_out[15:8];
      rcwt_pkg::OFS_TX_MOD:    rd_mux = {ctrl_bits_reg, preemp_en_out};
      rcwt_pkg::OFS_PWR_RB:    rd_mux = rssi_reg;
      rcwt_pkg::OFS_SQI_RB:    rd_mux = sqi_reg;
      rcwt_pkg::OFS_PRAM_PAGE: rd_mux = {4'h0, pram_page_out};
      rcwt_pkg::OFS_TX_BASE:   rd_mux = tx_base_out;
      rcwt_pkg::OFS_RX_BASE:   rd_mux = rx_base_out;
      rcwt_pkg::OFS_SLEEP_CFG: rd_mux = {1'b0, sleep_code_reg, 2'b00, wake_en_reg};
      rcwt_pkg::OFS_RLD_LOW:   rd_mux = reload_reg[7:0];
      rcwt_pkg::OFS_TMR_CTRL:  rd_mux = {6'h00, rc_osc_calibrate_enable_out,
                                         flag_clr_bit_reg};
      default:                 rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      rdata_out  <= 8'h00;
      rvalid_out <= 1'b0;
    end
    else
    begin
      rdata_out  <= req_in.rd ? rd_mux : 8'h00;
      rvalid_out <= req_in.rd;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_CHAN_MID: assert property (wr_mid |=> channel_word_hi_out[7:0] == $past(wd))
    else $error("Channel middle byte not written.");
  AST_PREEMP: assert property (wr_txm |=> preemp_en_out == $past(wd[0]))
    else $error("Preemphasis enable does not follow write.");
  AST_CTRL_OWNED: assert property (wr_txm && !ctrl_upd_in |=> $stable(ctrl_bits_reg))
    else $error("Host write changed controller bits.");
  AST_RO_PWR: assert property (!radio_in.upd |=> $stable(rssi_reg) && $stable(sqi_reg))
    else $error("Readback changed without radio update.");
  AST_DIV_STAGED: assert property (!wr_sleep |=> $stable(div_code_reg))
    else $error("Divider took effect without sleep write.");
  AST_RLD_STAGED: assert property (!wr_rl |=> $stable(reload_reg))
    else $error("Reload changed without low byte write.");
  AST_RLD_COMMIT: assert property (wr_rl |=> reload_reg == {$past(rld_stage_reg), $past(wd)})
    else $error("Reload commit value wrong.");
  AST_EXP_STICKY: assert property (expiry_flag_out && !flag_clr |=> expiry_flag_out)
    else $error("Expiry flag dropped without clear.");
  AST_FLAG_CLR: assert property (flag_clr && !expire |=> !expiry_flag_out && !cold_start_flag_out)
    else $error("Flags not cleared.");
  AST_EXPIRE: assert property (tick && timer_cnt_reg <= 16'h0001 && !wr_rl
                               |=> expiry_flag_out && timer_cnt_reg == $past(reload_reg))
    else $error("Timer expiry not raised or not reloaded.");
  AST_CAL_OFF: assert property (!rc_osc_calibrate_enable_out |=> !rc_calibration_done_out)
    else $error("Calibration done while disabled.");

  COV_EXPIRE:   cover property (expire && wake_en_reg);
  COV_CAL_DONE: cover property ($rose(rc_calibration_done_out));
  COV_CLR_RACE: cover property (flag_clr && expire);
  COV_COMMIT:   cover property (wr_rh ##[1:5] wr_rl);

endmodule : rcwt_regs
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                  core_clk_in = 1'b0;
  logic                  rst_n_in    = 1'b0;
  rcwt_pkg::rcwt_req_t   req         = '0;
  rcwt_pkg::rcwt_radio_t radio       = '0;
  logic                  ctrl_upd    = 1'b0;
  logic [6:0]            ctrl_bits   = 7'h00;
  logic                  slow_osc    = 1'b0;
  logic [7:0]            rdata;
  logic                  rvalid;
  logic [15:0]           chan_word;
  logic                  preemp;
  logic [3:0]            page;
  logic [7:0]            tx_base;
  logic [7:0]            rx_base;
  logic                  keep_ram;
  logic                  keep_xtal;
  logic                  keep_rc;
  logic                  wake;
  logic                  expiry;
  logic                  cold;
  logic                  cal_en;
  logic                  cal_done;
  logic [15:0]           lfsr        = 16'hBE64;
  int                    n_fail      = 0;
  int                    n_tests     = 0;
  int                    n_wake      = 0;

  // ------------
  // Design and clock
  // ------------
  // A short calibration time keeps the run brief; expectations use the same 10.
  rcwt_regs #(.CAL_CYCLES(10)) i_rcwt_regs (
    .core_clk_in                 (core_clk_in),
    .rst_n_in                    (rst_n_in),
    .req_in                      (req),
    .radio_in                    (radio),
    .ctrl_upd_in                 (ctrl_upd),
    .ctrl_bits_in                (ctrl_bits),
    .slow_osc_in                 (slow_osc),
    .rdata_out                   (rdata),
    .rvalid_out                  (rvalid),
    .channel_word_hi_out         (chan_word),
    .preemp_en_out               (preemp),
    .pram_page_out               (page),
    .tx_base_out                 (tx_base),
    .rx_base_out                 (rx_base),
    .keep_ram_out                (keep_ram),
    .keep_crystal_out            (keep_xtal),
    .keep_rc_out                 (keep_rc),
    .wake_req_out                (wake),
    .expiry_flag_out             (expiry),
    .cold_start_flag_out         (cold),
    .rc_osc_calibrate_enable_out (cal_en),
    .rc_calibration_done_out     (cal_done)
  );

  always #25 core_clk_in = ~core_clk_in;

  always @(posedge core_clk_in)
    if (wake === 1'b1)
      n_wake <= n_wake + 1;

  // ------------
  // Helpers
  // ------------
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step

  // Slow oscillator edges per timer tick for each divider code.
  function automatic int exp_div(input logic [2:0] c);
    case (c)
      3'h0:    return 1;
      3'h1:    return 4;
      3'h2:    return 8;
      3'h3:    return 16;
      3'h4:    return 128;
      3'h5:    return 1024;
      3'h6:    return 8192;
      default: return 65536;
    endcase
  endfunction : exp_div

  task automatic rnd(output logic [7:0] v);
    lfsr = lfsr_step(lfsr);
    v = lfsr[7:0];
  endtask : rnd

  task automatic finish_test;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
    end
  endtask : chk1

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_in);
    req <= '0;
    #1;
  endtask : wr

  // Read data is registered, so it is sampled just after the edge that took the read.
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    @(posedge core_clk_in);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk_in);
    req <= '0;
    #1;
    chk1(rvalid, 1'b1);
    chk8(rdata, e);
  endtask : rd_chk

  // Each slow edge gets nine fast cycles, enough for the synchroniser and one tick.
  task automatic slow(input int n);
    repeat (n)
    begin
      @(posedge core_clk_in);
      slow_osc <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      slow_osc <= 1'b0;
      repeat (4) @(posedge core_clk_in);
    end
    #1;
  endtask : slow

  // ------------
  // Main sequence
  // ------------
  initial
  begin
    logic [7:0] m, h, t, x, p, d;
    logic [3:0] codes [5];
    int k;
    codes = '{4'h1, 4'h4, 4'h5, 4'hB, 4'h2};
    repeat (16) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    #1;
    chk1(cold, 1'b1);
    chk1(preemp, 1'b1);
    rd_chk(10'h301, 8'hA9);
    rd_chk(10'h302, 8'h03);
    rd_chk(10'h306, 8'h01);
    rd_chk(10'h30C, 8'h00);
    rd_chk(10'h30D, 8'h00);
    rd_chk(10'h313, 8'h00);
    rd_chk(10'h314, 8'h80);
    rd_chk(10'h315, 8'h00);
    rd_chk(10'h317, 8'h00);
    rd_chk(10'h319, 8'h00);
    rd_chk(10'h31A, 8'h00);
    wr(10'h300, 8'h5A);
    rd_chk(10'h300, 8'h00);
    rd_chk(10'h31B, 8'h00);
    repeat (6)
    begin
      rnd(m);
      rnd(h);
      rnd(t);
      rnd(x);
      rnd(p);
      wr(10'h301, m);
      wr(10'h302, h);
      wr(10'h314, t);
      wr(10'h315, x);
      wr(10'h313, {4'h0, p[3:0]});
      chk8(chan_word[7:0], m);
      chk8(chan_word[15:8], h);
      chk8(tx_base, t);
      chk8(rx_base, x);
      chk8({4'h0, page}, {4'h0, p[3:0]});
      rd_chk(10'h301, m);
      rd_chk(10'h302, h);
      rd_chk(10'h313, {4'h0, p[3:0]});
    end
    for (k = 0; k < 4; k++)
    begin
      rnd(m);
      rnd(d);
      d[0] = k[0];
      @(posedge core_clk_in);
      ctrl_upd <= 1'b1;
      ctrl_bits <= m[6:0];
      @(posedge core_clk_in);
      ctrl_upd <= 1'b0;
      wr(10'h306, d);
      chk1(preemp, d[0]);
      rd_chk(10'h306, {m[6:0], d[0]});
      rnd(h);
      @(posedge core_clk_in);
      radio <= '{upd: 1'b1, rssi: m, sqi: h};
      @(posedge core_clk_in);
      radio.upd <= 1'b0;
      wr(10'h30C, ~m);
      wr(10'h30D, ~h);
      rd_chk(10'h30C, m);
      rd_chk(10'h30D, h);
    end
    foreach (codes[i])
    begin
      wr(10'h317, {1'b0, codes[i], 3'b000});
      @(posedge core_clk_in);
      #1;
      chk1(keep_ram, codes[i] == 4'h1 || codes[i] == 4'h5 || codes[i] == 4'hB);
      chk1(keep_xtal, codes[i] == 4'h4 || codes[i] == 4'h5);
      chk1(keep_rc, codes[i] == 4'hB);
      rd_chk(10'h317, {1'b0, codes[i], 3'b000});
    end
    wr(10'h316, 8'h00);
    wr(10'h317, 8'h29);
    wr(10'h318, 8'h00);
    wr(10'h319, 8'h03);
    wr(10'h31A, 8'h01);
    chk1(cold, 1'b0);
    chk1(expiry, 1'b0);
    slow(2);
    chk1(expiry, 1'b0);
    slow(1);
    chk1(expiry, 1'b1);
    chk1(n_wake == 1, 1'b1);
    repeat (10) @(posedge core_clk_in);
    #1;
    chk1(expiry, 1'b1);
    wr(10'h316, 8'h01);
    wr(10'h318, 8'h01);
    rd_chk(10'h316, 8'h00);
    rd_chk(10'h318, 8'h00);
    wr(10'h31A, 8'h01);
    slow(3);
    chk1(expiry, 1'b1);
    wr(10'h31A, 8'h01);
    chk1(expiry, 1'b0);
    slow(3);
    chk1(expiry, 1'b1);
    chk1(n_wake == 3, 1'b1);
    wr(10'h317, 8'h28);
    wr(10'h318, 8'h00);
    wr(10'h319, 8'h03);
    wr(10'h31A, 8'h01);
    slow(3 * exp_div(3'h1) - 1);
    chk1(expiry, 1'b0);
    slow(1);
    chk1(expiry, 1'b1);
    // Longer divider codes with a reload of one; the two longest would overrun the run budget.
    for (int c = 2; c < 6; c++)
    begin
      wr(10'h316, 8'(c));
      wr(10'h317, 8'h28);
      wr(10'h318, 8'h00);
      wr(10'h319, 8'h01);
      wr(10'h31A, 8'h01);
      chk1(expiry, 1'b0);
      slow(exp_div(3'(c)) - 1);
      chk1(expiry, 1'b0);
      slow(1);
      chk1(expiry, 1'b1);
    end
    chk1(n_wake == 3, 1'b1);
    wr(10'h31A, 8'h02);
    chk1(cal_en, 1'b1);
    chk1(cal_done, 1'b0);
    k = 0;
    while (cal_done !== 1'b1 && k < 40)
    begin
      @(posedge core_clk_in);
      #1;
      k++;
    end
    if (k == 40)
    begin
      n_fail++;
      $display("MISMATCH t=%0t calibration never finished", $time);
      finish_test();
    end
    chk1(k >= 8 && k <= 12, 1'b1);
    wr(10'h31A, 8'h00);
    @(posedge core_clk_in);
    #1;
    chk1(cal_en, 1'b0);
    chk1(cal_done, 1'b0);
    // A second reset in mid-run must bring back the cold start state.
    @(posedge core_clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    #1;
    chk1(cold, 1'b1);
    chk1(expiry, 1'b0);
    chk8(tx_base, 8'h80);
    finish_test();
  end
endmodule
`default_nettype wire
